/* shared/flash_led_consts.vh */
// Constants for the flash LED mode controller: register offsets,
// field positions, reset values and timing counts at a 25 MHz mclk.
`ifndef FLASH_LED_CONSTS_VH
`define FLASH_LED_CONSTS_VH
`define ADDR_ENABLE 8'h01
`define ADDR_MONITOR 8'h02
`define ADDR_FLASH1 8'h03
`define ADDR_FLASH2 8'h04
`define ADDR_TORCH1 8'h05
`define ADDR_TORCH2 8'h06
`define ADDR_TIMING 8'h08
`define ADDR_FLAGS1 8'h0A
`define ADDR_SECOND_FAULT_FLAGS 8'h0B
`define EN_LED_CHANNEL_ONE 0
`define EN_LED_CHANNEL_TWO 1
`define EN_MODE_LO 2
`define EN_MODE_HI 3
`define EN_TORCH_PIN 4
`define EN_STROBE_PIN 5
`define EN_NTC_SEL 6
`define EN_TX 7
`define MON_THR_HI 5
`define MON_THR_LO 3
`define MON_HYST 2
`define MON_MODE_HI 1
`define MON_MODE_LO 0
`define TIM_TOUT_HI 3
`define TIM_TOUT_LO 0
`define TIM_RAMP_HI 6
`define TIM_RAMP_LO 4
`define FL1_TIMEOUT 0
`define FL2_MONITOR 2
`define MODE_OFF 2'h0
`define MODE_IR 2'h1
`define MODE_TORCH 2'h2
`define MODE_FLASH 2'h3
`define MON_NONE 2'h0
`define MON_STOP 2'h1
`define MON_DOWN 2'h2
`define MON_UPDOWN 2'h3
`define RST_ENABLE 8'h83
`define RST_MONITOR 8'h00
`define RST_BRIGHT 8'h3F
`define RST_TIMING 8'h1A
`define CLK_HZ 25000000
`define CLK_NS 40
`define US_NS 1000
`define US_CYCLES (`US_NS / `CLK_NS)
`define MS_CYCLES_DEF (`CLK_HZ / 1000)
`define TOUT_BASE_MS 11'h028
`define TOUT_STEP_MS 11'h068
`define TORCH_STEP_BASE_US 12'h010
`endif

/* rtl/flash_led_mode_controller.v */
// Mode and current sequencing for a dual channel LED flash driver.
// Register accesses arrive already decoded from the serial interface on
// mclk; pins and analog comparator outputs are asynchronous.
`timescale 1ns/10ps
`include "flash_led_consts.vh"

module led_ramp (
  input wire mclk,
  input wire resetn,
  input wire active,
  input wire immediate,
  input wire step_en,
  input wire hold_up,
  input wire force_down,
  input wire [6:0] target,
  output reg on,
  output reg [6:0] level
);
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      on <= 1'b0;
      level <= 7'h00;
    end else if (!active) begin
      on <= 1'b0;
      level <= 7'h00;
    end else if (immediate) begin
      on <= 1'b1;
      level <= target;
    end else begin
      on <= 1'b1;
      // A fresh ramp shows the lowest level before the first step
      if (!on)
        level <= 7'h00;
      else if (level > target)
        level <= target;
      else if (step_en && force_down && level != 7'h00)
        level <= level - 7'h01;
      else if (step_en && !hold_up && !force_down && level < target)
        level <= level + 7'h01;
    end
  end
endmodule

module flash_led_mode_controller #(
  parameter MS_CYCLES = `MS_CYCLES_DEF
) (
  input wire mclk,
  input wire resetn,
  input wire hw_enable_pin,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire strobe_pin,
  input wire torch_pin,
  input wire tx_pin,
  input wire vout_ready,
  input wire supply_below,
  input wire supply_recovered,
  output wire led_channel_one_on,
  output wire [6:0] led_channel_one_level,
  output wire led_channel_two_on,
  output wire [6:0] led_channel_two_level,
  output reg pass_mode,
  output reg boost_enable,
  output wire [2:0] monitor_threshold,
  output wire monitor_hysteresis
);
  localparam integer MS_LAST_I = MS_CYCLES - 1;
  localparam integer US_LAST_I = `US_CYCLES - 1;
  localparam [15:0] MS_LAST = MS_LAST_I[15:0];
  localparam [4:0] US_LAST = US_LAST_I[4:0];
  reg [6:0] sync1, sync2;
  reg strobe_q, below_q, flash_on, flash_by_reg, ir_expired;
  reg stopped, lowering, no_raise;
  reg [7:0] enable_reg, monitor_reg, flash1, flash2, torch1, torch2;
  reg [7:0] timing_reg, flags1, second_fault_flags;
  reg [15:0] ms_cnt;
  reg [10:0] tout_ms;
  reg [4:0] us_cnt;
  reg [11:0] torch_cnt;

  // Bit order: enable, strobe, torch, tx, vout, below, recovered
  wire hw_en = sync2[0];
  wire strobe_s = sync2[1];
  wire torch_s = sync2[2];
  wire tx_s = sync2[3];
  wire vout_s = sync2[4];
  wire below_s = sync2[5];
  wire recov_s = sync2[6];
  wire [1:0] sw_mode = enable_reg[`EN_MODE_HI:`EN_MODE_LO];
  wire [1:0] mon_mode = monitor_reg[`MON_MODE_HI:`MON_MODE_LO];
  wire strobe_en = enable_reg[`EN_STROBE_PIN];
  wire strobe_rise = strobe_s & ~strobe_q;
  wire wr_ok = reg_wr & hw_en;
  wire rd_ok = reg_rd & hw_en;
  wire torch_active = !flash_on && (sw_mode == `MODE_TORCH ||
    (sw_mode == `MODE_OFF && enable_reg[`EN_TORCH_PIN] &&
     !enable_reg[`EN_NTC_SEL] && torch_s));
  wire ir_mode = (sw_mode == `MODE_IR);
  wire ir_on = ir_mode && strobe_en && strobe_s && !ir_expired;
  wire timing_run = flash_on || ir_on;
  wire ms_tick = timing_run && (ms_cnt == MS_LAST);
  wire [10:0] tout_limit = `TOUT_BASE_MS +
    `TOUT_STEP_MS * {7'h00, timing_reg[`TIM_TOUT_HI:`TIM_TOUT_LO]};
  wire timeout_hit = ms_tick && (tout_ms == tout_limit - 11'h001);
  wire us_tick = (us_cnt == US_LAST);
  wire [11:0] torch_period = `TORCH_STEP_BASE_US <<
    timing_reg[`TIM_RAMP_HI:`TIM_RAMP_LO];
  wire torch_tick = us_tick && (torch_cnt == torch_period - 12'h001);
  // Sync only counts while it can matter, so torch never sees it
  wire tx_act = flash_on && enable_reg[`EN_TX] && tx_s;
  wire use_torch = torch_active || tx_act;
  wire lamp_run = vout_s && (flash_on || torch_active);
  wire step_en = flash_on ? us_tick : torch_tick;
  wire hold_up = flash_on && (stopped || no_raise || lowering);
  wire force_down = flash_on && lowering;
  assign monitor_threshold = monitor_reg[`MON_THR_HI:`MON_THR_LO];
  assign monitor_hysteresis = monitor_reg[`MON_HYST];

  // Enable is sampled here too; no logic reads the first stage
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= 7'h00;
      sync2 <= 7'h00;
      strobe_q <= 1'b0;
      below_q <= 1'b0;
    end else begin
      sync1 <= {supply_recovered, supply_below, vout_ready, tx_pin,
                torch_pin, strobe_pin, hw_enable_pin};
      sync2 <= sync1;
      strobe_q <= sync2[1];
      below_q <= sync2[5];
    end
  end
  // Registers are held at defaults while the enable pin is low
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      enable_reg <= `RST_ENABLE;
      monitor_reg <= `RST_MONITOR;
      flash1 <= `RST_BRIGHT;
      flash2 <= `RST_BRIGHT;
      torch1 <= `RST_BRIGHT;
      torch2 <= `RST_BRIGHT;
      timing_reg <= `RST_TIMING;
    end else if (!hw_en) begin
      enable_reg <= `RST_ENABLE;
      monitor_reg <= `RST_MONITOR;
      flash1 <= `RST_BRIGHT;
      flash2 <= `RST_BRIGHT;
      torch1 <= `RST_BRIGHT;
      torch2 <= `RST_BRIGHT;
      timing_reg <= `RST_TIMING;
    end else if (wr_ok) begin
      case (reg_addr)
        `ADDR_ENABLE: enable_reg <= reg_wdata;
        `ADDR_MONITOR: monitor_reg <= reg_wdata;
        `ADDR_FLASH1: flash1 <= reg_wdata;
        `ADDR_FLASH2: flash2 <= reg_wdata;
        `ADDR_TORCH1: torch1 <= reg_wdata;
        `ADDR_TORCH2: torch2 <= reg_wdata;
        `ADDR_TIMING: timing_reg <= reg_wdata;
        default: enable_reg <= enable_reg;
      endcase
    end else if (timeout_hit && flash_by_reg) begin
      enable_reg[`EN_MODE_HI:`EN_MODE_LO] <= `MODE_OFF;
    end
  end
  // Flags clear on read; a new event in the read cycle survives
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flags1 <= 8'h00;
      second_fault_flags <= 8'h00;
      reg_rdata <= 8'h00;
    end else if (!hw_en) begin
      flags1 <= 8'h00;
      second_fault_flags <= 8'h00;
      reg_rdata <= 8'h00;
    end else begin
      if (rd_ok && reg_addr == `ADDR_FLAGS1)
        flags1 <= 8'h00;
      if (timeout_hit)
        flags1[`FL1_TIMEOUT] <= 1'b1;
      if (rd_ok && reg_addr == `ADDR_SECOND_FAULT_FLAGS)
        second_fault_flags <= 8'h00;
      if (below_s != below_q)
        second_fault_flags[`FL2_MONITOR] <= 1'b1;
      if (rd_ok) begin
        case (reg_addr)
          `ADDR_ENABLE: reg_rdata <= enable_reg;
          `ADDR_MONITOR: reg_rdata <= monitor_reg;
          `ADDR_FLASH1: reg_rdata <= flash1;
          `ADDR_FLASH2: reg_rdata <= flash2;
          `ADDR_TORCH1: reg_rdata <= torch1;
          `ADDR_TORCH2: reg_rdata <= torch2;
          `ADDR_TIMING: reg_rdata <= timing_reg;
          `ADDR_FLAGS1: reg_rdata <= flags1;
          `ADDR_SECOND_FAULT_FLAGS: reg_rdata <= second_fault_flags;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end
  // Flash sequencing; a pin flash lasts while the strobe stays high, until the timeout ends it
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flash_on <= 1'b0;
      flash_by_reg <= 1'b0;
      ir_expired <= 1'b0;
    end else if (!hw_en) begin
      flash_on <= 1'b0;
      flash_by_reg <= 1'b0;
      ir_expired <= 1'b0;
    end else begin
      if (timeout_hit && flash_on) begin
        flash_on <= 1'b0;
      end else if (flash_on) begin
        if (flash_by_reg ? sw_mode != `MODE_FLASH
                         : (!strobe_s || sw_mode != `MODE_OFF))
          flash_on <= 1'b0;
      end else if (sw_mode == `MODE_FLASH) begin
        flash_on <= 1'b1;
        flash_by_reg <= 1'b1;
      end else if (sw_mode == `MODE_OFF && strobe_en && strobe_rise) begin
        flash_on <= 1'b1;
        flash_by_reg <= 1'b0;
      end
      if (!strobe_s || !ir_mode)
        ir_expired <= 1'b0;
      else if (timeout_hit && ir_on)
        ir_expired <= 1'b1;
    end
  end
  // Timebases: microsecond ticks for stepping, milliseconds for timeout
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      us_cnt <= 5'h00;
      torch_cnt <= 12'h000;
      ms_cnt <= 16'h0000;
      tout_ms <= 11'h000;
    end else begin
      us_cnt <= us_tick ? 5'h00 : us_cnt + 5'h01;
      if (!torch_active || torch_tick)
        torch_cnt <= 12'h000;
      else if (us_tick)
        torch_cnt <= torch_cnt + 12'h001;
      if (!timing_run || ms_tick)
        ms_cnt <= 16'h0000;
      else
        ms_cnt <= ms_cnt + 16'h0001;
      if (!timing_run || timeout_hit)
        tout_ms <= 11'h000;
      else if (ms_tick)
        tout_ms <= tout_ms + 11'h001;
    end
  end
  // Supply monitor state, cleared between flashes
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stopped <= 1'b0;
      lowering <= 1'b0;
      no_raise <= 1'b0;
    end else if (!flash_on) begin
      stopped <= 1'b0;
      lowering <= 1'b0;
      no_raise <= 1'b0;
    end else begin
      if (mon_mode == `MON_STOP && below_s)
        stopped <= 1'b1;
      if ((mon_mode == `MON_DOWN || mon_mode == `MON_UPDOWN) && below_s)
        lowering <= 1'b1;
      else if (recov_s)
        lowering <= 1'b0;
      if (mon_mode == `MON_DOWN && below_s)
        no_raise <= 1'b1;
    end
  end
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pass_mode <= 1'b0;
      boost_enable <= 1'b0;
    end else begin
      pass_mode <= hw_en && ir_mode;
      boost_enable <= hw_en && (flash_on || torch_active || ir_mode);
    end
  end
  led_ramp ch_one (
    .mclk(mclk),
    .resetn(resetn),
    .active(enable_reg[`EN_LED_CHANNEL_ONE] && (lamp_run || ir_on)),
    .immediate(ir_mode),
    .step_en(step_en),
    .hold_up(hold_up),
    .force_down(force_down),
    .target(use_torch ? torch1[6:0] : flash1[6:0]),
    .on(led_channel_one_on),
    .level(led_channel_one_level)
  );
  led_ramp ch_two (
    .mclk(mclk),
    .resetn(resetn),
    .active(enable_reg[`EN_LED_CHANNEL_TWO] && (lamp_run || ir_on)),
    .immediate(ir_mode),
    .step_en(step_en),
    .hold_up(hold_up),
    .force_down(force_down),
    .target(use_torch ? torch2[6:0] : flash2[6:0]),
    .on(led_channel_two_on),
    .level(led_channel_two_level)
  );
endmodule

/* dv/flash_led_host_pins.sv */
// Host side pin model: drives the enable pin and says when commands
// may start. Assumes it shares mclk with the controller.
`timescale 1ns/10ps
module flash_led_host_pins #(
  parameter MS_CYCLES = 25
) (
  input wire mclk,
  input wire en_req,
  output reg hw_enable_pin,
  output reg cmd_ok
);
  integer waited = 0;
  initial begin
    hw_enable_pin = 1'b0;
    cmd_ok = 1'b0;
  end
  // Commands are held back 2 ms after every rise of the pin
  always @(negedge mclk) begin
    hw_enable_pin <= en_req;
    waited <= en_req ? waited + 1 : 0;
    cmd_ok <= en_req && waited >= 2 * MS_CYCLES;
  end
endmodule

/* dv/flash_led_mode_controller_props.sv */
// Port checker for the flash LED mode controller.
// Assumes one mclk domain and the async active low resetn.
`timescale 1ns/10ps
`include "flash_led_consts.vh"
module flash_led_props (
  input wire mclk,
  input wire resetn,
  input wire hw_enable_pin,
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire strobe_pin,
  input wire tx_pin,
  input wire vout_ready,
  input wire led_channel_one_on,
  input wire [6:0] led_channel_one_level,
  input wire led_channel_two_on,
  input wire pass_mode,
  input wire boost_enable,
  input wire [2:0] monitor_threshold,
  input wire monitor_hysteresis
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  shut_down_a: assert property (
    !hw_enable_pin [*6] |-> !boost_enable && !led_channel_one_on &&
    !led_channel_two_on && monitor_threshold == 3'h0 && !monitor_hysteresis)
    else $error("outputs active while disabled");
  mon_config_a: assert property (
    hw_enable_pin [*3] ##0 (reg_wr && reg_addr == `ADDR_MONITOR) |=>
    monitor_threshold == $past(reg_wdata[5:3]) &&
    monitor_hysteresis == $past(reg_wdata[2]))
    else $error("monitor fields not taken from write");
  vout_wait_a: assert property (
    !vout_ready [*4] ##0 !pass_mode |-> !$rose(led_channel_one_on))
    else $error("source on before output ready");
  ramp_zero_a: assert property (
    !pass_mode && $rose(led_channel_one_on) |-> led_channel_one_level == 7'h00)
    else $error("ramp did not start at lowest level");
  ramp_step_a: assert property (
    !tx_pin [*6] ##0 (!pass_mode && !$past(pass_mode) &&
    led_channel_one_on && $past(led_channel_one_on) &&
    led_channel_one_level > $past(led_channel_one_level)) |->
    led_channel_one_level == $past(led_channel_one_level) + 7'h01)
    else $error("ramp skipped a level");
  ir_pass_a: assert property (
    pass_mode |-> boost_enable)
    else $error("pass operation without converter on");
  ir_hold_a: assert property (
    pass_mode && $past(pass_mode) && led_channel_one_on &&
    $past(led_channel_one_on) |-> $stable(led_channel_one_level))
    else $error("level moved while pulsing");
  ir_level_a: assert property (
    !strobe_pin [*5] ##0 pass_mode |-> !led_channel_one_on)
    else $error("source on with strobe low");
endmodule
bind flash_led_mode_controller flash_led_props chk (
  .mclk(mclk),
  .resetn(resetn),
  .hw_enable_pin(hw_enable_pin),
  .reg_wr(reg_wr),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .strobe_pin(strobe_pin),
  .tx_pin(tx_pin),
  .vout_ready(vout_ready),
  .led_channel_one_on(led_channel_one_on),
  .led_channel_one_level(led_channel_one_level),
  .led_channel_two_on(led_channel_two_on),
  .pass_mode(pass_mode),
  .boost_enable(boost_enable),
  .monitor_threshold(monitor_threshold),
  .monitor_hysteresis(monitor_hysteresis)
);

/* dv/flash_led_mode_controller_tb_top.sv */
// Self-checking bench for the flash LED mode controller.
// Assumes the host pin model and the bound port checker.
`timescale 1ns/10ps
`include "flash_led_consts.vh"
`define CHK(g, e) begin num_checks = num_checks + 1; if ((g) !== (e)) \
  begin fails = fails + 1; $display("BAD %0t %h %h", $time, g, e); end end
module flash_led_mode_controller_tb_top;
  reg mclk = 1'b0, resetn = 1'b0, en_req = 1'b1, reg_wr = 1'b0;
  reg reg_rd = 1'b0, strobe_pin = 1'b0, torch_pin = 1'b0, tx_pin = 1'b0;
  reg vout_ready = 1'b1, below = 1'b0;
  reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  reg [6:0] lv;
  wire hw_en, cmd_ok, one_on, two_on, pass_mode, boost, hyst;
  wire [7:0] reg_rdata;
  wire [6:0] one_lvl, two_lvl;
  wire [2:0] thr;
  integer fails = 0, num_checks = 0, i, m;
  always #20 mclk = ~mclk;
  flash_led_host_pins #(.MS_CYCLES(25)) host (.mclk(mclk),
    .en_req(en_req), .hw_enable_pin(hw_en), .cmd_ok(cmd_ok));
  flash_led_mode_controller #(.MS_CYCLES(25)) DUT (.mclk(mclk),
    .resetn(resetn), .hw_enable_pin(hw_en), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .strobe_pin(strobe_pin), .torch_pin(torch_pin),
    .tx_pin(tx_pin), .vout_ready(vout_ready), .supply_below(below),
    .supply_recovered(!below), .led_channel_one_on(one_on),
    .led_channel_one_level(one_lvl), .led_channel_two_on(two_on),
    .led_channel_two_level(two_lvl), .pass_mode(pass_mode),
    .boost_enable(boost), .monitor_threshold(thr),
    .monitor_hysteresis(hyst));
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge mclk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] msk, input [7:0] e);
    begin
      @(negedge mclk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge mclk);
      reg_rd = 1'b0;
      `CHK(reg_rdata & msk, e)
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge mclk);
  endtask
  // Bounded wait for channel one to reach the given state
  task wait_on(input v);
    begin
      for (i = 0; i < 2000 && one_on !== v; i = i + 1)
        @(negedge mclk);
      `CHK(one_on, v)
    end
  endtask
  task wait_ok;
    for (i = 0; i < 500 && cmd_ok !== 1'b1; i = i + 1)
      @(negedge mclk);
  endtask
  task print_verdict;
    begin
      if (fails == 0 && num_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    #(40 * 30000);
    fails = fails + 1;
    print_verdict;
  end
  initial begin
    cyc(10);
    resetn = 1'b1;
    wait_ok;
    rd(`ADDR_ENABLE, 8'hFF, `RST_ENABLE);
    rd(`ADDR_FLASH1, 8'hFF, `RST_BRIGHT);
    rd(`ADDR_TORCH2, 8'hFF, `RST_BRIGHT);
    rd(`ADDR_TIMING, 8'hFF, `RST_TIMING);
    rd(8'h0F, 8'hFF, 8'h00);
    wr(`ADDR_MONITOR, 8'h2C);
    `CHK({thr, hyst}, 4'hB)
    wr(`ADDR_TIMING, 8'h00);
    wr(`ADDR_FLASH1, 8'h05);
    wr(`ADDR_TORCH1, 8'h02);
    vout_ready = 1'b0;
    wr(`ADDR_ENABLE, 8'h8D);
    cyc(10);
    `CHK(one_on, 1'b0)
    vout_ready = 1'b1;
    wait_on(1'b1);
    `CHK(one_lvl, 7'h00)
    cyc(150);
    `CHK({two_on, one_lvl}, 8'h05)
    tx_pin = 1'b1;
    cyc(5);
    `CHK(one_lvl, 7'h02)
    tx_pin = 1'b0;
    cyc(100);
    `CHK(one_lvl, 7'h05)
    tx_pin = 1'b1;
    wait_on(1'b0);
    tx_pin = 1'b0;
    rd(`ADDR_ENABLE, 8'hFF, 8'h81);
    rd(`ADDR_FLAGS1, 8'h01, 8'h01);
    wr(`ADDR_ENABLE, 8'h89);
    wait_on(1'b1);
    tx_pin = 1'b1;
    cyc(300);
    `CHK(one_lvl, 7'h00)
    cyc(800);
    `CHK({one_on, one_lvl}, 8'h82)
    tx_pin = 1'b0;
    wr(`ADDR_ENABLE, 8'h91);
    wait_on(1'b0);
    torch_pin = 1'b1;
    wait_on(1'b1);
    en_req = 1'b0;
    wait_on(1'b0);
    wr(`ADDR_MONITOR, 8'h38);
    torch_pin = 1'b0;
    en_req = 1'b1;
    cyc(3);
    wait_ok;
    rd(`ADDR_MONITOR, 8'hFF, 8'h00);
    wr(`ADDR_ENABLE, 8'hA7);
    cyc(3);
    `CHK({pass_mode, boost}, 2'h3)
    strobe_pin = 1'b1;
    wait_on(1'b1);
    `CHK(one_lvl, 7'h3F)
    `CHK({two_on, two_lvl}, 8'hBF)
    strobe_pin = 1'b0;
    wait_on(1'b0);
    wr(`ADDR_ENABLE, 8'hA1);
    strobe_pin = 1'b1;
    wait_on(1'b1);
    strobe_pin = 1'b0;
    wait_on(1'b0);
    wr(`ADDR_TIMING, 8'h00);
    // Each monitor mode must stop, lower, or lower then recover on a dip
    for (m = 1; m < 4; m = m + 1) begin
      wr(`ADDR_MONITOR, m[7:0]);
      wr(`ADDR_ENABLE, 8'h8D);
      cyc(100);
      lv = one_lvl;
      below = 1'b1;
      cyc(80);
      if (m > 1)
        `CHK(one_lvl < lv, 1'b1)
      below = 1'b0;
      cyc(10);
      lv = one_lvl;
      cyc(100);
      if (m < 3)
        `CHK(one_lvl, lv)
      else
        `CHK(one_lvl > lv, 1'b1)
      rd(`ADDR_SECOND_FAULT_FLAGS, 8'h04, 8'h04);
      wr(`ADDR_ENABLE, 8'h81);
      wait_on(1'b0);
    end
    // With the sync gate off the flash must not fall to torch level
    wr(`ADDR_TORCH1, 8'h01);
    wr(`ADDR_ENABLE, 8'h0D);
    cyc(100);
    lv = one_lvl;
    tx_pin = 1'b1;
    cyc(10);
    `CHK(one_lvl >= lv, 1'b1)
    tx_pin = 1'b0;
    wr(`ADDR_ENABLE, 8'h01);
    wait_on(1'b0);
    print_verdict;
  end
endmodule
